// *** core/nsc_ctl.sv ***
// Network state controller of a sensor node: start-up, boot-up,
// management commands, heartbeat status and service gating.
// Assumes a CAN controller that hands over parsed frames and takes
// one frame to send at a time; heartbeat timing is done outside.
//
// Operation
// RULE1: Initialise by itself after reset
// RULE2: Send boot-up frame after initialisation
// RULE3: Enter pre-operational, stay until command
// RULE4: Start-up setting chooses state after initialisation
// RULE5: No process data while pre-operational
// RULE6: Process and safety data only operational
// RULE7: Operational reads allowed, parameter writes refused
// RULE8: Stopped keeps only management and heartbeat; code also keeps lss_en_o on in stopped
// RULE9: Service gating table per state
// RULE10: Command frame: identifier 0, two bytes
// RULE11: Code 01h moves to operational
// RULE12: Code 02h moves to stopped
// RULE13: Code 80h moves to pre-operational
// RULE14: 81h node restart, 82h communication restart
// RULE15: Target zero addresses every node
// RULE16: Target 1..127 only matching node
// RULE17: Master alone initiates state changes
// RULE18: Status byte 00h/04h/05h/7Fh
// RULE19: Boot-up and heartbeat identifier 700h plus node
// RULE20: Unknown code or length ignored
// RULE21: Reset repeats init, boot-up, start-up
`timescale 1ns/1ns
module nsc_ctl (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [6:0]  node_id_i,
  input  wire logic        startup_oper_i,
  input  wire logic        hb_tick_i,
  input  wire logic        rx_valid_i,
  input  wire logic [10:0] rx_id_i,
  input  wire logic [3:0]  rx_dlc_i,
  input  wire logic [7:0]  rx_d0_i,
  input  wire logic [7:0]  rx_d1_i,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  output logic [10:0]      tx_id_o,
  output logic [3:0]       tx_dlc_o,
  output logic [7:0]       tx_data_o,
  output logic [7:0]       status_o,
  output logic             pdo_en_o,
  output logic             srdo_en_o,
  output logic             sdo_rd_en_o,
  output logic             sdo_wr_en_o,
  output logic             sync_en_o,
  output logic             time_en_o,
  output logic             emcy_en_o,
  output logic             lss_en_o,
  output logic             nmt_en_o,
  output logic             hb_en_o,
  output logic             app_rst_o,
  output logic             comm_rst_o
);
  // ==========================================================
  // Sub-blocks
  nsc_cmd_if cmd_bus ();
  nsc_tx_if  tx_bus ();

  nsc_cmd_dec u_dec (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .rx_valid_i (rx_valid_i),
    .rx_id_i    (rx_id_i),
    .rx_dlc_i   (rx_dlc_i),
    .rx_d0_i    (rx_d0_i),
    .rx_d1_i    (rx_d1_i),
    .node_id_i  (node_id_i),
    .cmd_bus    (cmd_bus)
  );

  nsc_hb_tx u_tx (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .tx_bus     (tx_bus),
    .node_id_i  (node_id_i),
    .tx_valid_o (tx_valid_o),
    .tx_ready_i (tx_ready_i),
    .tx_id_o    (tx_id_o),
    .tx_dlc_o   (tx_dlc_o),
    .tx_data_o  (tx_data_o)
  );

  // ==========================================================
  // State
  nsc_pkg::nsc_state_e state_r;
  nsc_pkg::nsc_state_e state_nxt;
  logic [7:0]          init_cnt_r;
  logic [7:0]          init_cnt_nxt;
  logic                hb_pend_r;
  logic                hb_pend_nxt;
  logic                start_oper_r;
  logic                app_rst_nxt;
  logic                comm_rst_nxt;

  wire running;
  wire init_done;
  wire cmd_ok;
  wire boot_send;
  wire hb_send;

  assign running   = (state_r == nsc_pkg::ST_PREOP) || (state_r == nsc_pkg::ST_OPER)
                     || (state_r == nsc_pkg::ST_STOPPED);
  assign init_done = (state_r == nsc_pkg::ST_INIT) && (init_cnt_r == nsc_pkg::INIT_CNT_ONE);
  // Commands during init or boot-up are dropped: the node is not yet on line
  assign cmd_ok    = cmd_bus.valid && running;
  assign boot_send = (state_r == nsc_pkg::ST_BOOT) && !tx_bus.busy; // RULE2
  // A command in the same cycle defers the heartbeat one cycle; a reset command drops it
  assign hb_send   = running && hb_pend_r && !tx_bus.busy && !cmd_ok;

  assign tx_bus.req    = boot_send || hb_send;
  assign tx_bus.status = nsc_pkg::nsc_status(state_r); // RULE18

  // ==========================================================
  // Next state
  always_comb
  begin
    state_nxt    = state_r;
    init_cnt_nxt = init_cnt_r;
    app_rst_nxt  = 1'b0;
    comm_rst_nxt = 1'b0;
    case (state_r)
      nsc_pkg::ST_INIT:
      begin
        init_cnt_nxt = init_cnt_r - nsc_pkg::INIT_CNT_ONE; // RULE1
        if (init_done)
        begin
          state_nxt = nsc_pkg::ST_BOOT;
        end
      end
      nsc_pkg::ST_BOOT:
      begin
        if (boot_send)
        begin
          // Start-up setting picks the first running state
          state_nxt = start_oper_r ? nsc_pkg::ST_OPER : nsc_pkg::ST_PREOP; // RULE3 RULE4
        end
      end
      nsc_pkg::ST_PREOP, nsc_pkg::ST_OPER, nsc_pkg::ST_STOPPED:
      begin
        // Only master commands move a running node
        if (cmd_ok) // RULE17
        begin
          case (cmd_bus.cmd)
            nsc_pkg::CMD_GO_OPER:  state_nxt = nsc_pkg::ST_OPER; // RULE11
            nsc_pkg::CMD_GO_STOP:  state_nxt = nsc_pkg::ST_STOPPED; // RULE12
            nsc_pkg::CMD_GO_PREOP: state_nxt = nsc_pkg::ST_PREOP; // RULE13
            nsc_pkg::CMD_RST_NODE:
            begin
              state_nxt    = nsc_pkg::ST_INIT; // RULE14 RULE21
              init_cnt_nxt = nsc_pkg::INIT_CYCLES;
              app_rst_nxt  = 1'b1;
            end
            nsc_pkg::CMD_RST_COMM:
            begin
              state_nxt    = nsc_pkg::ST_INIT; // RULE14 RULE21
              init_cnt_nxt = nsc_pkg::INIT_CYCLES;
              comm_rst_nxt = 1'b1;
            end
            default: state_nxt = state_r; // RULE20
          endcase
        end
      end
      default:
      begin
        state_nxt    = nsc_pkg::ST_INIT;
        init_cnt_nxt = nsc_pkg::INIT_CYCLES;
      end
    endcase
  end

  // Tick wins over the send that clears it
  assign hb_pend_nxt = running && (hb_tick_i || (hb_pend_r && !hb_send));

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_r    <= nsc_pkg::ST_INIT; // RULE1
      init_cnt_r <= nsc_pkg::INIT_CYCLES;
      hb_pend_r  <= 1'b0;
      app_rst_o  <= 1'b0;
      comm_rst_o <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      init_cnt_r <= init_cnt_nxt;
      hb_pend_r  <= hb_pend_nxt;
      app_rst_o  <= app_rst_nxt;
      comm_rst_o <= comm_rst_nxt;
    end
  end

  // Setting is caught at the end of each init, so a restart re-reads it
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      start_oper_r <= 1'b0;
    end
    else if (init_done)
    begin
      start_oper_r <= startup_oper_i; // RULE4
    end
  end

  // ==========================================================
  // Service gating
  wire is_pre;
  wire is_op;
  wire is_stop;

  assign is_pre  = (state_r == nsc_pkg::ST_PREOP);
  assign is_op   = (state_r == nsc_pkg::ST_OPER);
  assign is_stop = (state_r == nsc_pkg::ST_STOPPED);

  assign pdo_en_o    = is_op; // RULE5 RULE6
  assign srdo_en_o   = is_op; // RULE6
  assign sdo_rd_en_o = is_pre || is_op; // RULE7 RULE9
  // Parameter writes refused while operational
  assign sdo_wr_en_o = is_pre; // RULE7
  assign sync_en_o   = is_pre || is_op; // RULE9
  assign time_en_o   = is_pre || is_op; // RULE9
  assign emcy_en_o   = is_pre || is_op; // RULE9
  assign lss_en_o    = is_pre || is_stop; // RULE8 RULE9
  assign nmt_en_o    = running; // RULE8 RULE9
  assign hb_en_o     = running; // RULE8 RULE9
  assign status_o    = nsc_pkg::nsc_status(state_r); // RULE18

  // ==========================================================
  // Checks
  localparam int INIT_LEN = 200;

  logic [7:0] init_seen_r;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || state_r != nsc_pkg::ST_INIT)
    begin
      init_seen_r <= nsc_pkg::INIT_CNT_ZERO;
    end
    else
    begin
      init_seen_r <= init_seen_r + nsc_pkg::INIT_CNT_ONE;
    end
  end

  a_init_leaves_alone: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE1
    (state_r == nsc_pkg::ST_INIT && init_seen_r == 8'(INIT_LEN - 1))
      |=> state_r == nsc_pkg::ST_BOOT)
    else $error("init did not end by itself");

  a_init_no_early: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE1
    $rose(state_r == nsc_pkg::ST_BOOT) |-> $past(init_seen_r) == 8'(INIT_LEN - 1))
    else $error("init ended early");

  a_boot_frame_sent: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE2
    (state_r == nsc_pkg::ST_BOOT && !tx_bus.busy) |=>
      tx_valid_o && tx_data_o == nsc_pkg::HB_BOOT
      && tx_id_o == nsc_pkg::HB_COB_BASE + {4'h0, node_id_i}) // RULE19
    else $error("boot-up frame wrong");

  a_startup_state: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE3
    (state_r == nsc_pkg::ST_BOOT && !tx_bus.busy) |=>
      state_r == (start_oper_r ? nsc_pkg::ST_OPER : nsc_pkg::ST_PREOP)) // RULE4
    else $error("wrong start-up state");

  a_no_self_change: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE17
    (running && !cmd_bus.valid) |=> $stable(state_r))
    else $error("state changed without command");

  a_start_cmd: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE11
    (rx_valid_i && rx_id_i == nsc_pkg::NMT_COB_ID && rx_dlc_i == nsc_pkg::NMT_DLC
     && rx_d0_i == nsc_pkg::CODE_START && rx_d1_i == {1'b0, node_id_i} && running)
      |=> ##1 state_r == nsc_pkg::ST_OPER || !$past(running))
    else $error("start command not obeyed");

  a_stop_cmd: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE12
    (cmd_ok && cmd_bus.cmd == nsc_pkg::CMD_GO_STOP) |=> is_stop && !pdo_en_o && lss_en_o)
    else $error("stop command not obeyed");

  a_preop_cmd: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE13
    (cmd_ok && cmd_bus.cmd == nsc_pkg::CMD_GO_PREOP) |=> is_pre && !pdo_en_o && sdo_wr_en_o)
    else $error("pre-operational command not obeyed");

  a_reset_restart: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE21
    (cmd_ok && (cmd_bus.cmd == nsc_pkg::CMD_RST_NODE || cmd_bus.cmd == nsc_pkg::CMD_RST_COMM))
      |=> state_r == nsc_pkg::ST_INIT && (app_rst_o ^ comm_rst_o)) // RULE14
    else $error("reset command not obeyed");

  a_other_node: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE16
    (rx_valid_i && rx_d1_i != {1'b0, node_id_i} && rx_d1_i != 8'h00) |=> !cmd_bus.valid)
    else $error("frame for another node accepted");

  a_bad_length: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE20
    (rx_valid_i && rx_dlc_i != nsc_pkg::NMT_DLC) |=> !cmd_bus.valid)
    else $error("bad length frame accepted");

  a_gating_map: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE9
    running |-> (sdo_rd_en_o == !is_stop) && (lss_en_o == !is_op) && (pdo_en_o == is_op)
      && nmt_en_o && hb_en_o) // RULE8
    else $error("service gating wrong");

  a_status_byte: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE18
    is_op |-> status_o == nsc_pkg::HB_OPER)
    else $error("status byte wrong");

  a_status_others: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE18
    !is_op |-> status_o == (is_pre ? nsc_pkg::HB_PREOP :
                            (is_stop ? nsc_pkg::HB_STOPPED : nsc_pkg::HB_BOOT)))
    else $error("status byte wrong outside operational");

  // Nothing but the boot-up frame may leave a node that is not yet on line
  a_idle_gated: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE9
    !running |-> !pdo_en_o && !srdo_en_o && !sdo_rd_en_o && !sdo_wr_en_o && !sync_en_o
      && !time_en_o && !emcy_en_o && !lss_en_o && !nmt_en_o && !hb_en_o)
    else $error("service enabled before start-up");

  a_tx_holds: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE19
    (tx_valid_o && !tx_ready_i) |=> tx_valid_o && $stable(tx_id_o) && $stable(tx_dlc_o)
      && $stable(tx_data_o))
    else $error("frame changed before it was taken");

  a_hb_load: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE18
    hb_send |=> tx_valid_o && tx_data_o == $past(status_o))
    else $error("heartbeat frame carries wrong status");

  a_oper_writes: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE7
    is_op |-> sdo_rd_en_o && !sdo_wr_en_o)
    else $error("parameter access wrong while operational");

  c_boot_to_pre: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    state_r == nsc_pkg::ST_BOOT ##1 state_r == nsc_pkg::ST_PREOP);
  c_pre_to_oper: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    is_pre ##1 is_op);
  c_oper_to_stop: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    is_op ##1 is_stop);
  c_comm_reset: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    comm_rst_o);
  c_node_reset: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    app_rst_o);
endmodule // nsc_ctl

// *** pkg/nsc_pkg.sv ***
// Constants, states and commands of the network state controller.
// Assumes a 100 MHz system clock and frames delivered already parsed.
package nsc_pkg;
  // ==========================================================
  // Frame layout
  localparam logic [10:0] NMT_COB_ID   = 11'h000;
  localparam logic [3:0]  NMT_DLC      = 4'h2;
  localparam logic [6:0]  BCAST_NODE   = 7'h00;
  localparam logic [10:0] HB_COB_BASE  = 11'h700;
  localparam logic [3:0]  HB_DLC       = 4'h1;
  // ==========================================================
  // Command codes
  localparam logic [7:0]  CODE_START   = 8'h01;
  localparam logic [7:0]  CODE_STOP    = 8'h02;
  localparam logic [7:0]  CODE_PREOP   = 8'h80;
  localparam logic [7:0]  CODE_RST_ND  = 8'h81;
  localparam logic [7:0]  CODE_RST_COM = 8'h82;
  // ==========================================================
  // Heartbeat status bytes
  localparam logic [7:0]  HB_BOOT      = 8'h00;
  localparam logic [7:0]  HB_STOPPED   = 8'h04;
  localparam logic [7:0]  HB_OPER      = 8'h05;
  localparam logic [7:0]  HB_PREOP     = 8'h7f;
  // ==========================================================
  // Timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          INIT_TIME_NS  = 2000;
  localparam int          INIT_CYC_INT  = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  INIT_CYCLES   = INIT_CYC_INT[7:0];
  localparam logic [7:0]  INIT_CNT_ZERO = 8'h00;
  localparam logic [7:0]  INIT_CNT_ONE  = 8'h01;

  typedef enum logic [2:0] {ST_INIT, ST_BOOT, ST_PREOP, ST_OPER, ST_STOPPED} nsc_state_e;
  typedef enum logic [2:0] {CMD_NONE, CMD_GO_OPER, CMD_GO_STOP, CMD_GO_PREOP,
                            CMD_RST_NODE, CMD_RST_COMM} nsc_cmd_e;

  function automatic logic nsc_for_me(input logic [6:0] tgt, input logic [6:0] own);
    nsc_for_me = (tgt == BCAST_NODE) || (tgt == own);
  endfunction

  function automatic logic [7:0] nsc_status(input nsc_state_e st);
    case (st)
      ST_PREOP:   nsc_status = HB_PREOP;
      ST_OPER:    nsc_status = HB_OPER;
      ST_STOPPED: nsc_status = HB_STOPPED;
      default:    nsc_status = HB_BOOT;
    endcase
  endfunction
endpackage

// *** pkg/nsc_if.sv ***
// Internal carriers: decoded commands and frame requests.
// Both ends sit on the same system clock.
`timescale 1ns/1ns
interface nsc_cmd_if;
  logic              valid;
  nsc_pkg::nsc_cmd_e cmd;
  modport dec (output valid, output cmd);
  modport ctl (input valid, input cmd);
endinterface

interface nsc_tx_if;
  logic       req;
  logic [7:0] status;
  logic       busy;
  modport ctl (output req, output status, input busy);
  modport tx  (input req, input status, output busy);
endinterface

// *** core/nsc_cmd_dec.sv ***
// Management frame decoder: filters identifier, length, code and target.
// Assumes rx_valid_i is a one-cycle strobe per received frame.
`timescale 1ns/1ns
module nsc_cmd_dec (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       rx_valid_i,
  input  wire logic [10:0] rx_id_i,
  input  wire logic [3:0] rx_dlc_i,
  input  wire logic [7:0] rx_d0_i,
  input  wire logic [7:0] rx_d1_i,
  input  wire logic [6:0] node_id_i,
  nsc_cmd_if.dec          cmd_bus
);
  wire               frame_ok;
  wire               target_ok;
  nsc_pkg::nsc_cmd_e code_dec;
  wire               code_ok;

  // Wrong length or unknown code is dropped silently
  assign frame_ok  = rx_valid_i && (rx_id_i == nsc_pkg::NMT_COB_ID)
                     && (rx_dlc_i == nsc_pkg::NMT_DLC); // RULE10 RULE20
  // Top bit of the target byte must be clear: only 0..127 can match
  assign target_ok = !rx_d1_i[7] && nsc_pkg::nsc_for_me(rx_d1_i[6:0], node_id_i); // RULE15 RULE16
  assign code_dec  = (rx_d0_i == nsc_pkg::CODE_START)   ? nsc_pkg::CMD_GO_OPER  :
                     (rx_d0_i == nsc_pkg::CODE_STOP)    ? nsc_pkg::CMD_GO_STOP  :
                     (rx_d0_i == nsc_pkg::CODE_PREOP)   ? nsc_pkg::CMD_GO_PREOP :
                     (rx_d0_i == nsc_pkg::CODE_RST_ND)  ? nsc_pkg::CMD_RST_NODE :
                     (rx_d0_i == nsc_pkg::CODE_RST_COM) ? nsc_pkg::CMD_RST_COMM :
                                                          nsc_pkg::CMD_NONE; // RULE20
  assign code_ok   = (code_dec != nsc_pkg::CMD_NONE);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cmd_bus.valid <= 1'b0;
      cmd_bus.cmd   <= nsc_pkg::CMD_NONE;
    end
    else
    begin
      cmd_bus.valid <= frame_ok && target_ok && code_ok;
      cmd_bus.cmd   <= code_dec;
    end
  end
endmodule // nsc_cmd_dec

// *** core/nsc_hb_tx.sv ***
// Boot-up and heartbeat frame holder: one frame in flight at a time.
// Assumes the CAN controller takes the frame when tx_ready_i is high.
`timescale 1ns/1ns
module nsc_hb_tx (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  nsc_tx_if.tx             tx_bus,
  input  wire logic [6:0]  node_id_i,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  output logic [10:0]      tx_id_o,
  output logic [3:0]       tx_dlc_o,
  output logic [7:0]       tx_data_o
);
  wire load;
  wire done;

  assign load        = tx_bus.req && !tx_valid_o;
  assign done        = tx_valid_o && tx_ready_i;
  assign tx_bus.busy = tx_valid_o;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tx_valid_o <= 1'b0;
      tx_id_o    <= nsc_pkg::HB_COB_BASE;
      tx_dlc_o   <= nsc_pkg::HB_DLC;
      tx_data_o  <= nsc_pkg::HB_BOOT;
    end
    else if (load)
    begin
      tx_valid_o <= 1'b1;
      tx_id_o    <= nsc_pkg::HB_COB_BASE + {4'h0, node_id_i}; // RULE19
      tx_dlc_o   <= nsc_pkg::HB_DLC;
      tx_data_o  <= tx_bus.status; // RULE18
    end
    else if (done)
    begin
      tx_valid_o <= 1'b0;
    end
  end
endmodule // nsc_hb_tx

// *** test/nsc_mgr_model.sv ***
// Network manager and CAN controller stand-in for the state controller.
// Assumes the system clock only; the bench calls its tasks to send frames.
`timescale 1ns/1ns
module nsc_mgr_model (
  input  wire logic        sys_clk_i,
  input  wire logic        slow_i,
  input  wire logic        tx_valid_i,
  input  wire logic [10:0] tx_id_i,
  input  wire logic [3:0]  tx_dlc_i,
  input  wire logic [7:0]  tx_data_i,
  output logic             rx_valid_o,
  output logic [10:0]      rx_id_o,
  output logic [3:0]       rx_dlc_o,
  output logic [7:0]       rx_d0_o,
  output logic [7:0]       rx_d1_o,
  output logic             tx_ready_o
);
  logic [1:0]  gap_r    = 2'h0;
  logic [10:0] got_id   = 11'h000;
  logic [3:0]  got_dlc  = 4'h0;
  logic [7:0]  got_data = 8'h00;
  int          frames   = 0;

  initial
  begin
    rx_valid_o = 1'b0;
    rx_id_o    = 11'h7ff;
    rx_dlc_o   = 4'hf;
    rx_d0_o    = 8'hff;
    rx_d1_o    = 8'hff;
    tx_ready_o = 1'b0;
  end

  // ==========================================================
  // Frame taker: slow mode accepts only one cycle in four
  always @(posedge sys_clk_i)
  begin
    gap_r      <= gap_r + 2'h1;
    tx_ready_o <= !slow_i || (gap_r == 2'h2);
    if (tx_valid_i && tx_ready_o)
    begin
      got_id   <= tx_id_i;
      got_dlc  <= tx_dlc_i;
      got_data <= tx_data_i;
      frames   <= frames + 1;
    end
  end

  // ==========================================================
  // Management commands: only this model ever starts a state change
  task automatic send(input logic [10:0] id, input logic [3:0] dlc,
                      input logic [7:0] d0, input logic [7:0] d1);
    @(posedge sys_clk_i);
    rx_valid_o <= 1'b1;
    rx_id_o    <= id;
    rx_dlc_o   <= dlc;
    rx_d0_o    <= d0;
    rx_d1_o    <= d1;
  endtask

  // Released fields show the inverse so a stale value cannot pass
  task automatic idle();
    @(posedge sys_clk_i);
    rx_valid_o <= 1'b0;
    rx_id_o    <= ~rx_id_o;
    rx_dlc_o   <= ~rx_dlc_o;
    rx_d0_o    <= ~rx_d0_o;
    rx_d1_o    <= ~rx_d1_o;
  endtask
endmodule // nsc_mgr_model

// *** test/tb.sv ***
// Self-checking bench of the network state controller.
// Assumes node address 05h and the 200-cycle initialisation of the design.
`timescale 1ns/1ns
module tb;
  typedef struct {logic [10:0] id; logic [3:0] dlc; logic [7:0] d0; logic [7:0] d1;
                  logic [7:0] st;} nsc_row_s;
  logic sys_clk_i, rst_i, startup_oper_i, hb_tick_i, slow;
  logic rx_valid_i, tx_ready_i, tx_valid_o, app_rst_o, comm_rst_o;
  logic [10:0] rx_id_i, tx_id_o;
  logic [3:0]  rx_dlc_i, tx_dlc_o;
  logic [7:0]  rx_d0_i, rx_d1_i, tx_data_o, status_o;
  logic [9:0]  en;
  int          err_count = 0, comparisons = 0, cyc = 0, app_cnt = 0, com_cnt = 0, n0;
  nsc_row_s    rows[10] = '{
    '{11'h000, 4'h2, 8'h01, 8'h00, 8'h05},
    '{11'h000, 4'h2, 8'h02, 8'h05, 8'h04},
    '{11'h000, 4'h2, 8'h80, 8'h05, 8'h7f},
    '{11'h000, 4'h2, 8'h01, 8'h06, 8'h7f},
    '{11'h000, 4'h2, 8'h01, 8'h85, 8'h7f},
    '{11'h000, 4'h3, 8'h01, 8'h00, 8'h7f},
    '{11'h001, 4'h2, 8'h01, 8'h00, 8'h7f},
    '{11'h000, 4'h2, 8'h03, 8'h00, 8'h7f},
    '{11'h000, 4'h2, 8'h01, 8'h05, 8'h05},
    '{11'h000, 4'h2, 8'h02, 8'h00, 8'h04}};

  nsc_ctl u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .node_id_i(7'h05),
    .startup_oper_i(startup_oper_i), .hb_tick_i(hb_tick_i), .rx_valid_i(rx_valid_i),
    .rx_id_i(rx_id_i), .rx_dlc_i(rx_dlc_i), .rx_d0_i(rx_d0_i), .rx_d1_i(rx_d1_i),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_id_o(tx_id_o),
    .tx_dlc_o(tx_dlc_o), .tx_data_o(tx_data_o), .status_o(status_o), .pdo_en_o(en[9]),
    .srdo_en_o(en[8]), .sdo_rd_en_o(en[7]), .sdo_wr_en_o(en[6]), .sync_en_o(en[5]),
    .time_en_o(en[4]), .emcy_en_o(en[3]), .lss_en_o(en[2]), .nmt_en_o(en[1]),
    .hb_en_o(en[0]), .app_rst_o(app_rst_o), .comm_rst_o(comm_rst_o));

  nsc_mgr_model u_mgr (.sys_clk_i(sys_clk_i), .slow_i(slow), .tx_valid_i(tx_valid_o),
    .tx_id_i(tx_id_o), .tx_dlc_i(tx_dlc_o), .tx_data_i(tx_data_o), .rx_valid_o(rx_valid_i),
    .rx_id_o(rx_id_i), .rx_dlc_o(rx_dlc_i), .rx_d0_o(rx_d0_i), .rx_d1_o(rx_d1_i),
    .tx_ready_o(tx_ready_i));

  // ==========================================================
  // Clock, cycle ceiling and reset pulse counters
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
  begin
    cyc++;
    app_cnt += int'(app_rst_o === 1'b1);
    com_cnt += int'(comm_rst_o === 1'b1);
    if (cyc == 20000)
    begin
      err_count++;
      stop_test();
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [9:0] en_exp(input logic [7:0] st);
    logic op, pre, stp;
    op     = (st == 8'h05);
    pre    = (st == 8'h7f);
    stp    = (st == 8'h04);
    en_exp = {op, op, pre | op, pre, pre | op, pre | op, pre | op, pre | stp,
              pre | op | stp, pre | op | stp};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_state(input logic [7:0] st);
    chk("status", 16'(st), 16'(status_o));
    chk("enables", 16'(en_exp(st)), 16'(en));
  endtask

  // Waits for the next frame taken by the far side, bounded
  task automatic take_frame(input logic [7:0] data);
    n0 = u_mgr.frames;
    for (int i = 0; i < 400 && u_mgr.frames == n0; i++) @(posedge sys_clk_i);
    #1;
    chk("frame count", 16'(n0 + 1), 16'(u_mgr.frames));
    chk("frame id", 16'h0705, 16'(u_mgr.got_id));
    chk("frame dlc", 16'h0001, 16'(u_mgr.got_dlc));
    chk("frame data", 16'(data), 16'(u_mgr.got_data));
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    startup_oper_i = 1'b0;
    hb_tick_i = 1'b0;
    slow = 1'b0;
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk_state(8'h00);
    take_frame(8'h00);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk_state(8'h7f);
    $display("test startup done");
    foreach (rows[i])
    begin
      u_mgr.send(rows[i].id, rows[i].dlc, rows[i].d0, rows[i].d1);
      u_mgr.idle();
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk_state(rows[i].st);
    end
    $display("test command table done");
    // Back to back commands, then a heartbeat while the taker stalls
    u_mgr.send(11'h000, 4'h2, 8'h01, 8'h00);
    u_mgr.send(11'h000, 4'h2, 8'h80, 8'h05);
    u_mgr.idle();
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk_state(8'h7f);
    @(posedge sys_clk_i);
    slow <= 1'b1;
    hb_tick_i <= 1'b1;
    @(posedge sys_clk_i);
    hb_tick_i <= 1'b0;
    take_frame(8'h7f);
    slow <= 1'b0;
    $display("test back to back and heartbeat done");
    // Communication reset, broadcast
    com_cnt = 0;
    u_mgr.send(11'h000, 4'h2, 8'h82, 8'h00);
    u_mgr.idle();
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk_state(8'h00);
    take_frame(8'h00);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("comm reset pulses", 16'h0001, 16'(com_cnt));
    chk_state(8'h7f);
    $display("test communication reset done");
    // Node reset with start-up setting operational; command during init dropped
    app_cnt = 0;
    u_mgr.send(11'h000, 4'h2, 8'h81, 8'h05);
    startup_oper_i <= 1'b1;
    u_mgr.idle();
    repeat (5) @(posedge sys_clk_i);
    u_mgr.send(11'h000, 4'h2, 8'h02, 8'h05);
    u_mgr.idle();
    take_frame(8'h00);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("node reset pulses", 16'h0001, 16'(app_cnt));
    chk_state(8'h05);
    $display("test node reset done");
    // Mid-run reset while operational; setting still asks for operational
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk_state(8'h00);
    chk("tx valid after reset", 16'h0000, 16'(tx_valid_o));
    take_frame(8'h00);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk_state(8'h05);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule // tb
